/* atpo_pkg.sv */
`default_nettype none
package atpo_pkg;
    localparam int          CLK_HZ       = 125_000_000;
    localparam int          FRAME_TICKS  = 4096;
    localparam int          NREG         = 7;
    localparam logic [11:0] FRAME_LAST   = 12'hfff;

    localparam logic [11:0] OFF_CTRL     = 12'h000;
    localparam logic [11:0] OFF_RATE     = 12'h004;
    localparam logic [11:0] OFF_START    = 12'h008;
    localparam logic [11:0] OFF_OFFSET   = 12'h00c;
    localparam logic [11:0] OFF_GAIN     = 12'h010;
    localparam logic [11:0] OFF_CLAMP    = 12'h014;
    localparam logic [11:0] OFF_BREAK    = 12'h018;
    localparam logic [11:0] OFF_STATUS   = 12'h01c;

    localparam logic [2:0]  IDX_CTRL     = 3'h0;
    localparam logic [2:0]  IDX_RATE     = 3'h1;
    localparam logic [2:0]  IDX_START    = 3'h2;
    localparam logic [2:0]  IDX_OFFSET   = 3'h3;
    localparam logic [2:0]  IDX_GAIN     = 3'h4;
    localparam logic [2:0]  IDX_CLAMP    = 3'h5;
    localparam logic [2:0]  IDX_BREAK    = 3'h6;
    localparam logic [2:0]  IDX_STATUS   = 3'h7;

    localparam int          B_INV        = 0;
    localparam int          B_SLEW       = 1;
    localparam int          B_DRV        = 2;
    localparam int          B_FBS        = 4;
    localparam int          B_BREAK_HYSTERESIS_SEL       = 5;
    localparam int          B_REP        = 7;
    localparam int          B_EFR        = 9;
    localparam int          B_FILT       = 10;
    localparam int          B_HCLAMP     = 16;

    localparam logic [NREG-1:0][31:0] REG_MASK = {
        32'h0000_3fff, 32'h01ff_01ff, 32'h0000_ffff, 32'h0000_0fff,
        32'h0000_3fff, 32'h0000_0007, 32'h0000_07ff};
    localparam logic [NREG-1:0][31:0] REG_RST = {
        32'h0000_2000, 32'h019a_0066, 32'h0000_0400, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    localparam logic [11:0] HCLAMP_BASE  = 12'he00;
    localparam logic [11:0] FAIL_LOW     = 12'h040;
    localparam logic [11:0] FAIL_HIGH    = 12'hfc0;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

    typedef enum logic [1:0] {
        DRV_PUSH_PULL = 2'b00,
        DRV_PULL_DOWN = 2'b01,
        DRV_PULL_UP   = 2'b10,
        DRV_SERIAL    = 2'b11
    } atpo_drv_e;

    function automatic logic [13:0] break_hysteresis_sel_lsb(input logic [1:0] sel);
        case (sel)
            2'b01:   break_hysteresis_sel_lsb = 14'h0038;
            2'b10:   break_hysteresis_sel_lsb = 14'h005b;
            2'b11:   break_hysteresis_sel_lsb = 14'h0089;
            default: break_hysteresis_sel_lsb = 14'h0000;
        endcase
    endfunction

    // Frame rate in Hz per select code; divider gives one PWM clock
    function automatic logic [7:0] frame_div(input logic [2:0] sel);
        int hz;
        case (sel)
            3'h0:    hz = 2000;
            3'h1:    hz = 1000;
            3'h2:    hz = 800;
            3'h3:    hz = 500;
            3'h4:    hz = 400;
            3'h5:    hz = 250;
            3'h6:    hz = 200;
            default: hz = 125;
        endcase
        frame_div = 8'(CLK_HZ / (hz * FRAME_TICKS));
    endfunction
endpackage
`default_nettype wire

/* atpo_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module atpo_filter
    import atpo_pkg::*;
(
    input  wire logic        aclk,      // Clock
    input  wire logic        aresetn,   // Sync reset, low
    input  wire logic        ce,        // Clock enable
    input  wire logic        en,        // Filter on
    input  wire logic [13:0] angle_in,  // Raw angle
    input  wire logic        angle_stb, // New sample
    output logic      [13:0] angle_out  // Filtered angle
);
    logic [13:0] diff;
    logic [13:0] step;

    // Modular difference keeps the wrap from 16383 to 0 a small step
    assign diff = angle_in - angle_out;
    assign step = {diff[13], diff[13:1]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            angle_out <= 14'h0000;
        end else if (ce && angle_stb) begin
            if (en) begin
                angle_out <= angle_out + step;
            end else begin
                angle_out <= angle_in;
            end
        end
    end

    a_filt_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && angle_stb && !en) |=> angle_out == $past(angle_in))
        else $error("bypassed filter did not pass the angle");

    a_filt_half: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && angle_stb && en && angle_in == angle_out) |=>
        $stable(angle_out))
        else $error("filter moved at zero error");
endmodule
`default_nettype wire

/* atpo_top.sv */
// Function
// - Angle maps linearly onto 12-bit output
// - Output held between low and high clamp, except in diagnostic mode
// - Clamps set through nine low bits
// - Breakpoint forces output to the low clamp
// - Breakpoint hysteresis 0, 56, 91, 137 LSB
// - Optional angle filter, code one enables
// - Diagnostic mode drives a failure band
// - Band select zero lower, one upper
// - Transfer repeats one to four times
// - Extended field range bit boosts input
// - Driver push-pull, pull-down or pull-up
// - Driver codes 00 01 10, 11 serial
// - Duty cycle follows transfer result
// - Frames 4096 PWM clocks, back to back
// - Frame opens high for low clamp
// - Frame closes low for high clamp
// - Invert complements the whole frame
// - Frame rate and slew from settings
// - Slew bit zero fast, one slow
`timescale 1ns/1ps
`default_nettype none
module atpo_top
    import atpo_pkg::*;
(
    input  wire logic        aclk,          // Clock, 125 MHz
    input  wire logic        aresetn,       // Sync reset, low
    input  wire logic        ce,            // Clock enable
    input  wire logic [13:0] angle_in,      // Measured angle
    input  wire logic        angle_stb,     // Angle sample strobe
    input  wire logic        diag_fault,    // Diagnostic request
    input  wire logic [11:0] s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic      [1:0]  s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [11:0] s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic      [31:0] s_axi_rdata,   // Read data
    output logic      [1:0]  s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    output logic             pin_out,       // Output pin level
    output logic             pin_oe,        // Output pin drive
    output logic             edge_slow,     // Slow edge select
    output logic             serial_sel,    // Serial protocol select
    output logic             afe_range_ext  // Extended field range
);
    logic [NREG-1:0][31:0] regs_q;
    logic [NREG-1:0][31:0] act_q;
    logic [11:0] aw_addr_q;
    logic        aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        w_have_q;
    logic [7:0]  presc_q;
    logic [11:0] tick_q;
    logic [11:0] duty_q;
    logic [11:0] value_q;
    logic [11:0] value_d;
    logic        side_q;
    logic        side_d;
    logic        level_q;
    logic [13:0] angle_f;
    logic [16:0] rep_prod;
    logic [13:0] rel;
    logic [13:0] bp_rel;
    logic [13:0] break_hysteresis_sel;
    logic [29:0] lin_prod;
    logic [18:0] lin_sum;
    logic [11:0] lo;
    logic [11:0] hi;
    logic        pwm_tick;
    logic        frame_end;
    logic        level;
    logic [31:0] status;
    atpo_drv_e   drv;
    logic [3:0]  wr_dec;
    logic [3:0]  rd_dec;

    // Returns index plus valid flag for a byte address
    function automatic logic [3:0] reg_decode(input logic [11:0] a);
        case (a)
            OFF_CTRL:   reg_decode = {1'b1, IDX_CTRL};
            OFF_RATE:   reg_decode = {1'b1, IDX_RATE};
            OFF_START:  reg_decode = {1'b1, IDX_START};
            OFF_OFFSET: reg_decode = {1'b1, IDX_OFFSET};
            OFF_GAIN:   reg_decode = {1'b1, IDX_GAIN};
            OFF_CLAMP:  reg_decode = {1'b1, IDX_CLAMP};
            OFF_BREAK:  reg_decode = {1'b1, IDX_BREAK};
            OFF_STATUS: reg_decode = {1'b1, IDX_STATUS};
            default:    reg_decode = 4'h0;
        endcase
    endfunction

    // AXI4-Lite write: address and data are taken in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_dec        = reg_decode(aw_addr_q);
    assign rd_dec        = reg_decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_have_q && w_have_q) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_dec[3] ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Status is read-only; writes there are accepted and dropped
    generate
        for (genvar i = 0; i < NREG; i++) begin : g_reg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    regs_q[i] <= REG_RST[i];
                end else if (ce && aw_have_q && w_have_q &&
                             wr_dec == {1'b1, 3'(i)}) begin
                    for (int b = 0; b < 4; b++) begin
                        if (w_strb_q[b]) begin
                            regs_q[i][8*b +: 8] <= w_data_q[8*b +: 8] &
                                                   REG_MASK[i][8*b +: 8];
                        end
                    end
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    act_q[i] <= REG_RST[i];
                end else if (ce && frame_end) begin
                    act_q[i] <= regs_q[i];
                end
            end
        end
    endgenerate

    assign status = {16'h0000, 1'b0, diag_fault, level_q, side_q, value_q};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_dec[3] ? RESP_OKAY : RESP_SLVERR;
                if (!rd_dec[3]) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else if (rd_dec[2:0] == IDX_STATUS) begin
                    s_axi_rdata <= status;
                end else begin
                    s_axi_rdata <= regs_q[rd_dec[2:0]];
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    atpo_filter u_filter (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .en        (act_q[IDX_CTRL][B_FILT]),
        .angle_in  (angle_in),
        .angle_stb (angle_stb),
        .angle_out (angle_f)
    );

    // Transfer function datapath
    assign rep_prod = angle_f * {1'b0, act_q[IDX_CTRL][B_REP +: 2]} +
                      {3'h0, angle_f};
    assign rel      = rep_prod[13:0] - act_q[IDX_START][13:0];
    assign bp_rel   = act_q[IDX_BREAK][13:0] - act_q[IDX_START][13:0];
    assign break_hysteresis_sel     = break_hysteresis_sel_lsb(act_q[IDX_CTRL][B_BREAK_HYSTERESIS_SEL +: 2]);
    assign lin_prod = rel * act_q[IDX_GAIN][15:0];
    assign lin_sum  = {7'h00, act_q[IDX_OFFSET][11:0]} +
                      {1'b0, lin_prod[29:12]};
    assign lo       = {3'h0, act_q[IDX_CLAMP][8:0]};
    assign hi       = HCLAMP_BASE | {3'h0, act_q[IDX_CLAMP][B_HCLAMP +: 9]};

    always_comb begin
        side_d = side_q;
        if (!side_q && {1'b0, rel} >= {1'b0, bp_rel} + {1'b0, break_hysteresis_sel}) begin
            side_d = 1'b1;
        end else if (side_q && {1'b0, rel} + {1'b0, break_hysteresis_sel} < {1'b0, bp_rel}) begin
            side_d = 1'b0;
        end
    end

    always_comb begin
        if (diag_fault) begin
            value_d = act_q[IDX_CTRL][B_FBS] ? FAIL_HIGH : FAIL_LOW;
        end else if (side_q) begin
            value_d = lo;
        end else if (lin_sum > {7'h00, hi}) begin
            value_d = hi;
        end else if (lin_sum < {7'h00, lo}) begin
            value_d = lo;
        end else begin
            value_d = lin_sum[11:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            side_q  <= 1'b0;
            value_q <= 12'h000;
        end else if (ce) begin
            side_q  <= side_d;
            value_q <= value_d;
        end
    end

    // PWM frame timing
    assign pwm_tick  = presc_q == frame_div(act_q[IDX_RATE][2:0]) - 8'h01;
    assign frame_end = pwm_tick && tick_q == FRAME_LAST;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_q <= 8'h00;
            tick_q  <= 12'h000;
            duty_q  <= 12'h000;
        end else if (ce) begin
            presc_q <= pwm_tick ? 8'h00 : presc_q + 8'h01;
            if (pwm_tick) begin
                tick_q <= tick_q + 12'h001;
            end
            if (frame_end) begin
                duty_q <= value_q;
            end
        end
    end

    // High while tick below duty: the low clamp gives the opening high
    // run, the high clamp the closing low run.
    assign level = (tick_q < duty_q) ^ act_q[IDX_CTRL][B_INV];
    assign drv   = atpo_drv_e'(act_q[IDX_CTRL][B_DRV +: 2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q       <= 1'b0;
            pin_out       <= 1'b0;
            pin_oe        <= 1'b0;
            edge_slow     <= 1'b0;
            serial_sel    <= 1'b0;
            afe_range_ext <= 1'b0;
        end else if (ce) begin
            level_q       <= level;
            edge_slow     <= act_q[IDX_CTRL][B_SLEW];
            afe_range_ext <= act_q[IDX_CTRL][B_EFR];
            serial_sel    <= drv == DRV_SERIAL;
            case (drv)
                DRV_PUSH_PULL: begin
                    pin_out <= level;
                    pin_oe  <= 1'b1;
                end
                DRV_PULL_DOWN: begin
                    pin_out <= 1'b0;
                    pin_oe  <= !level;
                end
                DRV_PULL_UP: begin
                    pin_out <= 1'b1;
                    pin_oe  <= level;
                end
                // Serial protocol lives elsewhere; pin released here
                default: begin
                    pin_out <= 1'b0;
                    pin_oe  <= 1'b0;
                end
            endcase
        end
    end

    a_frame_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && frame_end) |=> tick_q == 12'h000 && presc_q == 8'h00)
        else $error("frame did not wrap after 4096 ticks");

    a_clamp_range: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(aresetn) && $past(ce) && !$past(diag_fault)) |->
        value_q >= $past(lo) && value_q <= $past(hi))
        else $error("output left the clamp window");

    a_clamp_floor: assert property (@(posedge aclk) disable iff (!aresetn)
        hi >= 12'he00 && lo <= 12'h1ff)
        else $error("clamp level beyond nine-bit reach");

    a_fail_band: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && diag_fault) |=>
        value_q == ($past(act_q[IDX_CTRL][B_FBS]) ? 12'hfc0 : 12'h040))
        else $error("diagnostic band value wrong");

    a_break_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && side_q && !diag_fault) |=> value_q == $past(lo))
        else $error("past breakpoint output not at low clamp");

    a_break_hysteresis_sel_enter: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(side_q) |->
        {1'b0, $past(rel)} >= {1'b0, $past(bp_rel)} + {1'b0, $past(break_hysteresis_sel)})
        else $error("breakpoint crossed inside hysteresis");

    a_cfg_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !(ce && frame_end) |=> $stable(act_q))
        else $error("settings changed inside a frame");

    a_pp_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && drv == DRV_PUSH_PULL) |=> pin_oe && pin_out == $past(level))
        else $error("push-pull pin not driven with level");

    a_pd_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && drv == DRV_PULL_DOWN) |=> !pin_out && pin_oe == !$past(level))
        else $error("pull-down stage drove high");

    a_duty_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && frame_end) |=> duty_q == $past(value_q))
        else $error("duty not taken at frame end");

    a_slew_out: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> edge_slow == $past(act_q[IDX_CTRL][B_SLEW]))
        else $error("slew output does not follow setting");

    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && aw_have_q && w_have_q) |=> s_axi_bvalid)
        else $error("no write response after address and data");
endmodule
`default_nettype wire

/* atpo_pwm_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module atpo_pwm_decoder (
    input  wire logic        aclk,    // Clock
    input  wire logic        aresetn, // Sync reset, low
    input  wire logic        line,    // Resolved output wire
    output logic      [31:0] rise_at, // Cycle of last rising edge
    output logic      [31:0] fall_at, // Cycle of last falling edge
    output logic      [7:0]  rises    // Rising edges seen
);
    logic [31:0] cnt_q;
    logic        prev_q;

    // Edge stamps let the controller recover frame start and high time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q   <= 32'h0;
            prev_q  <= line;
            rise_at <= 32'h0;
            fall_at <= 32'h0;
            rises   <= 8'h0;
        end else begin
            cnt_q  <= cnt_q + 32'h1;
            prev_q <= line;
            if (line && !prev_q) begin
                rise_at <= cnt_q;
                rises   <= rises + 8'h1;
            end
            if (!line && prev_q) begin
                fall_at <= cnt_q;
            end
        end
    end
endmodule
`default_nettype wire

/* atpo_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module atpo_top_tb import atpo_pkg::*; ();
    localparam int TICK = 125_000_000 / (2000 * 4096);
    localparam int EXP  = (FRAME_TICKS + 512) * TICK;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        ce = 1'b1;
    logic [13:0] angle_in = 14'h0800;
    logic        angle_stb = 1'b1;
    logic        diag_fault = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rise_at, fall_at;
    logic [7:0]  rises;
    logic        pin_out, pin_oe, edge_slow, serial_sel, afe_range_ext;
    int          failures = 0;
    int          samples_checked = 0;
    // Pull-up on the wire: an undriven pin reads high, as at the controller
    wire logic   line = pin_oe ? pin_out : 1'b1;

    always #4 aclk = ~aclk;

    atpo_top DUT (.aclk, .aresetn, .ce, .angle_in, .angle_stb, .diag_fault,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pin_out, .pin_oe, .edge_slow, .serial_sel,
        .afe_range_ext);

    atpo_pwm_decoder PEER (.aclk, .aresetn, .line, .rise_at, .fall_at,
        .rises);

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic timeout();
        failures++;
        $display("BAD wait expected answer seen timeout");
        end_of_test();
    endtask

    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_win(input string what, input int lo, input int hi,
                             input logic [31:0] g);
        samples_checked++;
        if ($isunknown(g) || g < 32'(lo) || g > 32'(hi)) begin
            failures++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, g);
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int n;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 64)
            timeout();
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 64)
            timeout();
        @(posedge aclk);
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(OFF_CLAMP, d, r);
        check("clamp reset", 32'h019a_0066, d);
        axi_rd(OFF_BREAK, d, r);
        check("break reset", 32'h0000_2000, d);
        axi_rd(OFF_GAIN, d, r);
        check("gain reset", 32'h0000_0400, d);
        axi_rd(12'h020, d, r);
        check("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
        check("unmapped read data", 32'h0, d);
        axi_wr(12'h020, 32'hffff_ffff, r);
        check("unmapped write resp", 32'(RESP_SLVERR), 32'(r));
        axi_wr(OFF_STATUS, 32'hffff_ffff, r);
        check("status write resp", 32'(RESP_OKAY), 32'(r));
        // Clamps stay at defaults and the filter stays off
        axi_wr(OFF_CTRL, 32'h0000_0203, r);
        axi_rd(OFF_CTRL, d, r);
        check("ctrl readback", 32'h0000_0203, d);
        check("slew before frame end", 32'h0, 32'(edge_slow));
        check("range before frame end", 32'h0, 32'(afe_range_ext));
        check("level before frame end", 32'h0, 32'(line));
        check("push-pull drive", 32'h1, 32'(pin_oe));
        for (n = 0; n < 80000 && rises == 8'h0; n++)
            @(posedge aclk);
        if (rises == 8'h0)
            timeout();
        // Inverted frame: low for the duty, then high
        check_win("rise cycle", EXP - 3, EXP + 5, rise_at);
        check_win("last fall", 0, 4, fall_at);
        repeat (2) @(posedge aclk);
        check("slow edges", 32'h1, 32'(edge_slow));
        check("extended range", 32'h1, 32'(afe_range_ext));
        check("serial select", 32'h0, 32'(serial_sel));
        check("drive after frame", 32'h1, 32'(pin_oe));
        axi_rd(OFF_STATUS, d, r);
        check("status", 32'h0000_2200, d);
        // Diagnostic request forces the lower band with band select clear
        diag_fault <= 1'b1;
        repeat (3) @(posedge aclk);
        axi_rd(OFF_STATUS, d, r);
        check("diag status", 32'h0000_4040, d & 32'h0000_5fff);
        diag_fault <= 1'b0;
        repeat (3) @(posedge aclk);
        axi_rd(OFF_STATUS, d, r);
        check("diag released", 32'h0000_0200, d & 32'h0000_5fff);
        end_of_test();
    end
endmodule
`default_nettype wire
